/* File: include/dma_pkg.sv */
/*
 Constants, field layouts and carrier types of the dual-address DMA channel.
 Assumes a 32-bit AXI4-Lite register bus and a 64-bit system bus on one clock.
*/
package dma_pkg;
   // ==========================================================================
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_SRC  = 8'h08;
   localparam logic [7:0] OFS_DST  = 8'h0C;
   localparam logic [7:0] OFS_CNT  = 8'h10;
   localparam logic [7:0] OFS_SINC = 8'h14;
   localparam logic [7:0] OFS_DINC = 8'h18;
   localparam logic [7:0] OFS_MCTL = 8'h1C;
   // ==========================================================================
   // Status fields and error causes
   localparam int         ST_CONFIG_ERROR_FLAG  = 4;
   localparam int         ST_DONE   = 5;
   localparam int         ST_BUSY   = 6;
   localparam logic [3:0] CAUSE_CFG = 4'h1;
   localparam logic [3:0] CAUSE_BUS = 4'h2;
   // ==========================================================================
   // Transfer size codes
   localparam logic [2:0] SZ_1B   = 3'h0;
   localparam logic [2:0] SZ_2B   = 3'h1;
   localparam logic [2:0] SZ_4B   = 3'h2;
   localparam logic [2:0] SZ_8B   = 3'h3;
   localparam logic [2:0] SZ_4DW  = 3'h4;
   localparam logic [2:0] SZ_8DW  = 3'h5;
   localparam logic [2:0] SZ_16DW = 3'h6;
   localparam logic [2:0] SZ_32DW = 3'h7;
   // ==========================================================================
   // Size of the staging buffer, burst limits, burst increments and bus responses
   localparam int         FIFO_DEPTH = 8;
   localparam logic [5:0] BOUND_DW   = 6'h20;
   localparam logic [31:0] INC_POS8  = 32'h0000_0008;
   localparam logic [31:0] INC_NEG8  = 32'hFFFF_FFF8;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // ==========================================================================
   // Carrier types
   typedef struct packed {
      logic        err_ie;
      logic        dst_burst_inhibit;
      logic        src_burst_inhibit;
      logic        size_mode;
      logic        byte_reverse;
      logic        single_addr_select;
      logic [2:0]  xfer_size;
   } chan_ctrl_s;
   localparam chan_ctrl_s CTRL_RESET = '0;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [5:0]  len;
      logic [3:0]  bytes;
      logic [63:0] wdata;
   } mem_req_s;
endpackage

/* File: logic/dma_dual_address_burst.sv */
/*
 Dual-address channel of the DMA engine: register slave, settings check,
 shifting staging buffer and burst splitter toward the system bus.
 Assumes the system bus pulses MEM_ACK_I once per beat of a raised request
 and that all inputs are synchronous to CORE_CLK_I.
*/
`timescale 1ns/10ps
module dma_dual_address_burst
(
   // Clock and reset
   input  wire logic              CORE_CLK_I,
   input  wire logic              RST_I,
   // AXI4-Lite register slave
   input  wire logic              S_AXI_AWVALID_I,
   output      logic              S_AXI_AWREADY_O,
   input  wire logic [7:0]        S_AXI_AWADDR_I,
   input  wire logic              S_AXI_WVALID_I,
   output      logic              S_AXI_WREADY_O,
   input  wire logic [31:0]       S_AXI_WDATA_I,
   input  wire logic [3:0]        S_AXI_WSTRB_I,
   output      logic              S_AXI_BVALID_O,
   input  wire logic              S_AXI_BREADY_I,
   output      logic [1:0]        S_AXI_BRESP_O,
   input  wire logic              S_AXI_ARVALID_I,
   output      logic              S_AXI_ARREADY_O,
   input  wire logic [7:0]        S_AXI_ARADDR_I,
   output      logic              S_AXI_RVALID_O,
   input  wire logic              S_AXI_RREADY_I,
   output      logic [31:0]       S_AXI_RDATA_O,
   output      logic [1:0]        S_AXI_RRESP_O,
   // System bus master
   output      dma_pkg::mem_req_s MEM_REQ_O,
   input  wire logic              MEM_ACK_I,
   input  wire logic              MEM_ERR_I,
   input  wire logic [63:0]       MEM_RDATA_I,
   // Buffer sharing and error interrupt
   input  wire logic              FIFO_BUSY_I,
   output      logic              FIFO_LOCK_O,
   output      logic              ERR_IRQ_O
);
   typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_RD, ST_WR, ST_FIN} state_e;

   // ==========================================================================
   // Register state
   dma_pkg::chan_ctrl_s ctrl, next_ctrl;
   logic [31:0] src_address, dst_address, src_increment, dst_increment;
   logic [31:0] next_src_address, next_dst_address, next_src_increment, next_dst_increment;
   logic [23:0] byte_count, next_byte_count, src_left, next_src_left;
   logic        fifo_use_enable, next_fifo_use_enable;
   logic [6:0]  chan_status_reg, next_chan_status_reg;
   logic        aw_got, w_got, next_aw_got, next_w_got, start, next_start;
   logic [7:0]  aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic        bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0]  bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   logic        awready, wready, arready, next_awready, next_wready, next_arready;
   // Engine state
   state_e      state, next_state;
   dma_pkg::mem_req_s req, next_req;
   logic [5:0]  beats, next_beats;
   logic [63:0] fifo_mem [dma_pkg::FIFO_DEPTH];
   logic [2:0]  wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [3:0]  fifo_cnt, next_fifo_cnt;
   logic        lock, next_lock, irq, next_irq, cfg_err_evt, push;
   logic [63:0] push_data;

   // Burst length to the next size boundary, or a whole size when full, capped at the 32 double word boundary
   function automatic logic [5:0] chunk(input logic [31:0] a, input logic neg,
                                        input logic [5:0] sz, input logic full);
      logic [4:0] off;
      logic [5:0] to_sz, to_bnd, r;
      off    = a[7:3] & 5'(sz - 6'h01);
      to_sz  = neg ? 6'(off) + 6'h01 : sz - 6'(off);
      to_bnd = neg ? 6'(a[7:3]) + 6'h01 : dma_pkg::BOUND_DW - 6'(a[7:3]);
      r      = full ? sz : to_sz;
      return (to_bnd < r) ? to_bnd : r;
   endfunction

   // Size decode
   logic       burst_ok, dw_path, neg_src, neg_dst, offs_differ;
   logic [5:0] size_dw, rd_len, wr_len, items_left;
   logic [3:0] step;
   logic [23:0] step24;
   always_comb
   begin
      burst_ok = (ctrl.xfer_size == dma_pkg::SZ_4DW || ctrl.xfer_size == dma_pkg::SZ_8DW)
                 && fifo_use_enable;
      size_dw  = (ctrl.xfer_size == dma_pkg::SZ_8DW) ? 6'h08 : 6'h04;
      dw_path  = ctrl.xfer_size >= dma_pkg::SZ_8B;
      step     = dw_path ? 4'h8 : 4'(4'h1 << ctrl.xfer_size);
      step24   = 24'(step);
      neg_src  = src_increment[31];
      neg_dst  = dst_increment[31];
      offs_differ = ((src_address[7:3] ^ dst_address[7:3]) & 5'(size_dw - 6'h01)) != 5'h00;
      items_left = (src_left >= 24'(8) * step24) ? 6'h08
                   : 6'(src_left >> (dw_path ? 2'h3 : ctrl.xfer_size[1:0]));
      if (burst_ok && !ctrl.src_burst_inhibit)
         rd_len = chunk(src_address, neg_src, size_dw, ctrl.size_mode);
      else
         rd_len = 6'h01;
      if (rd_len > items_left)
         rd_len = items_left;
      if (burst_ok && !ctrl.dst_burst_inhibit)
         wr_len = chunk(dst_address, neg_dst, size_dw, ctrl.size_mode);
      else
         wr_len = 6'h01;
      if (wr_len > 6'(fifo_cnt))
         wr_len = 6'(fifo_cnt);
   end

   // Settings check
   logic cfg_bad;
   always_comb
   begin
      cfg_bad = 1'b0;
      unique case (ctrl.xfer_size)
         dma_pkg::SZ_1B:
            cfg_bad = ctrl.byte_reverse;
         dma_pkg::SZ_2B:
            cfg_bad = byte_count[0] | src_increment[0] | dst_increment[0]
                      | ctrl.byte_reverse;
         dma_pkg::SZ_4B:
            cfg_bad = (byte_count[1:0] != 2'h0) | (src_increment[1:0] != 2'h0)
                      | (dst_increment[1:0] != 2'h0) | ctrl.byte_reverse;
         dma_pkg::SZ_16DW, dma_pkg::SZ_32DW:
            cfg_bad = 1'b1;
         default:
         begin
            if (burst_ok)
               cfg_bad = ctrl.byte_reverse
                  | !(src_increment == dma_pkg::INC_POS8 || src_increment == dma_pkg::INC_NEG8)
                  | !(dst_increment == dma_pkg::INC_POS8 || dst_increment == dma_pkg::INC_NEG8
                      || (ctrl.dst_burst_inhibit && dst_increment == 32'h0000_0000));
            else
               cfg_bad = (byte_count[2:0] != 3'h0) | (src_address[2:0] != {3{neg_src}})
                  | (dst_address[2:0] != {3{neg_dst}}) | (src_increment[2:0] != 3'h0)
                  | (dst_increment[2:0] != 3'h0);
         end
      endcase
   end

   // Byte shifter and optional reversal on the way into the buffer
   logic [5:0]  rot;
   logic [63:0] rotated;
   always_comb
   begin
      // Descending addresses hold their offset inverted, so undo that first
      rot     = {3'((dst_address[2:0] ^ {3{neg_dst}}) - (src_address[2:0] ^ {3{neg_src}})), 3'h0};
      rotated = (MEM_RDATA_I << rot) | (MEM_RDATA_I >> (7'h40 - 7'(rot)));
      push_data = rotated;
      for (int b = 0; b < 8; b++)
         if (ctrl.byte_reverse)
            push_data[8*b +: 8] = rotated[8*(7-b) +: 8];
   end

   // ==========================================================================
   // Transfer engine next state
   always_comb
   begin
      next_state = state;
      next_req = req;
      next_beats = beats;
      next_src_address = src_address;
      next_dst_address = dst_address;
      next_src_left = src_left;
      next_byte_count = byte_count;
      next_rd_ptr = rd_ptr;
      next_lock = lock;
      cfg_err_evt = 1'b0;
      push = 1'b0;
      unique case (state)
         ST_IDLE:
            if (start && !ctrl.single_addr_select)
               next_state = ST_CHECK;
         ST_CHECK:
         begin
            if (cfg_bad)
            begin
               cfg_err_evt = 1'b1;
               next_state = ST_IDLE;
            end
            else if (byte_count == 24'h0)
               next_state = ST_FIN;
            else if (!(burst_ok && FIFO_BUSY_I))
            begin
               next_src_left = byte_count;
               next_lock = burst_ok && !ctrl.size_mode && offs_differ;
               next_state = ST_RD;
            end
         end
         ST_RD:
            if (!req.valid)
            begin
               next_req = '{valid: 1'b1, write: 1'b0, addr: src_address, len: rd_len,
                            bytes: step, wdata: 64'h0};
               next_beats = rd_len;
            end
            else if (MEM_ERR_I)
               next_state = ST_IDLE;
            else if (MEM_ACK_I)
            begin
               push = 1'b1;
               next_src_address = src_address + src_increment;
               next_src_left = src_left - step24;
               next_beats = beats - 6'h01;
               if (beats == 6'h01)
               begin
                  next_req.valid = 1'b0;
                  next_state = ST_WR;
               end
            end
         ST_WR:
            if (!req.valid)
            begin
               next_req = '{valid: 1'b1, write: 1'b1, addr: dst_address, len: wr_len,
                            bytes: step, wdata: fifo_mem[rd_ptr]};
               next_beats = wr_len;
            end
            else if (MEM_ERR_I)
               next_state = ST_IDLE;
            else if (MEM_ACK_I)
            begin
               next_rd_ptr = rd_ptr + 3'h1;
               next_req.wdata = fifo_mem[next_rd_ptr];
               next_dst_address = dst_address + dst_increment;
               next_byte_count = byte_count - step24;
               next_beats = beats - 6'h01;
               if (beats == 6'h01)
               begin
                  next_req.valid = 1'b0;
                  if (fifo_cnt != 4'h1)
                     next_state = ST_WR;
                  else if (byte_count == step24)
                     next_state = ST_FIN;
                  else
                     next_state = ST_RD;
               end
            end
         ST_FIN:
            next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
      if (next_state == ST_IDLE || next_state == ST_FIN)
      begin
         next_req.valid = 1'b0;
         next_lock = 1'b0;
      end
      next_wr_ptr = wr_ptr + 3'(push);
      next_fifo_cnt = fifo_cnt + 4'(push) - 4'(next_rd_ptr != rd_ptr);
   end

   // Staging buffer storage, written on each read beat
   always_ff @(posedge CORE_CLK_I)
   begin
      if (push)
         fifo_mem[wr_ptr] <= push_data;
   end

   // ==========================================================================
   // Register slave next state
   always_comb
   begin
      next_aw_got = aw_got;
      next_w_got = w_got;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      next_ctrl = ctrl;
      next_src_increment = src_increment;
      next_dst_increment = dst_increment;
      next_fifo_use_enable = fifo_use_enable;
      next_start = 1'b0;
      next_chan_status_reg = chan_status_reg;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
      begin
         next_aw_got = 1'b1;
         next_aw_addr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O)
      begin
         next_w_got = 1'b1;
         next_w_data = S_AXI_WDATA_I;
      end
      if (aw_got && w_got)
      begin
         next_aw_got = 1'b0;
         next_w_got = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = dma_pkg::RESP_OKAY;
         unique case (aw_addr)
            dma_pkg::OFS_CTRL:
            begin
               next_ctrl = dma_pkg::chan_ctrl_s'(w_data[9:1]);
               next_start = w_data[0] && state == ST_IDLE;
            end
            dma_pkg::OFS_STAT:
               next_chan_status_reg[5:0] = chan_status_reg[5:0] & ~w_data[5:0];
            dma_pkg::OFS_SINC: next_src_increment = w_data;
            dma_pkg::OFS_DINC: next_dst_increment = w_data;
            dma_pkg::OFS_MCTL: next_fifo_use_enable = w_data[0];
            dma_pkg::OFS_SRC, dma_pkg::OFS_DST, dma_pkg::OFS_CNT: ;
            default: next_bresp = dma_pkg::RESP_DECERR;
         endcase
      end
      if (bvalid && S_AXI_BREADY_I)
         next_bvalid = 1'b0;
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
      begin
         next_rvalid = 1'b1;
         next_rresp = dma_pkg::RESP_OKAY;
         unique case (S_AXI_ARADDR_I)
            dma_pkg::OFS_CTRL: next_rdata = {22'h0, ctrl, chan_status_reg[dma_pkg::ST_BUSY]};
            dma_pkg::OFS_STAT: next_rdata = {25'h0, chan_status_reg};
            dma_pkg::OFS_SRC:  next_rdata = src_address;
            dma_pkg::OFS_DST:  next_rdata = dst_address;
            dma_pkg::OFS_CNT:  next_rdata = {8'h0, byte_count};
            dma_pkg::OFS_SINC: next_rdata = src_increment;
            dma_pkg::OFS_DINC: next_rdata = dst_increment;
            dma_pkg::OFS_MCTL: next_rdata = {31'h0, fifo_use_enable};
            default:
            begin
               next_rdata = 32'h0000_0000;
               next_rresp = dma_pkg::RESP_DECERR;
            end
         endcase
      end
      else if (rvalid && S_AXI_RREADY_I)
         next_rvalid = 1'b0;
      // Hardware events set status after the software clear, so a set wins
      if (cfg_err_evt)
         next_chan_status_reg[dma_pkg::ST_CONFIG_ERROR_FLAG:0] = {1'b1, dma_pkg::CAUSE_CFG};
      if (req.valid && MEM_ERR_I)
         next_chan_status_reg[3:0] = dma_pkg::CAUSE_BUS;
      if (state == ST_FIN)
         next_chan_status_reg[dma_pkg::ST_DONE] = 1'b1;
      next_chan_status_reg[dma_pkg::ST_BUSY] = next_state != ST_IDLE;
      next_irq = ctrl.err_ie && (next_chan_status_reg[3:0] != 4'h0);
      // Ready flags registered so the bus sees them straight from flip-flops
      next_awready = !next_aw_got && !next_bvalid;
      next_wready = !next_w_got && !next_bvalid;
      next_arready = !next_rvalid;
   end

   // Address and count registers are shared by software writes and the engine
   logic [31:0] sw_src, sw_dst;
   logic [23:0] sw_cnt;
   always_comb
   begin
      sw_src = next_src_address;
      sw_dst = next_dst_address;
      sw_cnt = next_byte_count;
      if (aw_got && w_got && state == ST_IDLE)
      begin
         if (aw_addr == dma_pkg::OFS_SRC) sw_src = w_data;
         if (aw_addr == dma_pkg::OFS_DST) sw_dst = w_data;
         if (aw_addr == dma_pkg::OFS_CNT) sw_cnt = w_data[23:0];
      end
   end

   // ==========================================================================
   // State registers
   always_ff @(posedge CORE_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         state <= ST_IDLE;  req <= '0;  beats <= 6'h00;
         src_address <= 32'h0;  dst_address <= 32'h0;  byte_count <= 24'h0;
         src_left <= 24'h0;  src_increment <= 32'h0;  dst_increment <= 32'h0;
         wr_ptr <= 3'h0;  rd_ptr <= 3'h0;  fifo_cnt <= 4'h0;  lock <= 1'b0;
         ctrl <= dma_pkg::CTRL_RESET;  fifo_use_enable <= 1'b0;  start <= 1'b0;
         chan_status_reg <= 7'h00;  irq <= 1'b0;  aw_got <= 1'b0;  w_got <= 1'b0;
         aw_addr <= 8'h00;  w_data <= 32'h0;  bvalid <= 1'b0;  bresp <= 2'h0;
         rvalid <= 1'b0;  rresp <= 2'h0;  rdata <= 32'h0;
         awready <= 1'b1;  wready <= 1'b1;  arready <= 1'b1;
      end
      else
      begin
         state <= next_state;  req <= next_req;  beats <= next_beats;
         src_address <= sw_src;  dst_address <= sw_dst;  byte_count <= sw_cnt;
         src_left <= next_src_left;  src_increment <= next_src_increment;
         dst_increment <= next_dst_increment;  wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;  fifo_cnt <= next_fifo_cnt;  lock <= next_lock;
         ctrl <= next_ctrl;  fifo_use_enable <= next_fifo_use_enable;
         start <= next_start;  chan_status_reg <= next_chan_status_reg;  irq <= next_irq;
         aw_got <= next_aw_got;  w_got <= next_w_got;  aw_addr <= next_aw_addr;
         w_data <= next_w_data;  bvalid <= next_bvalid;  bresp <= next_bresp;
         rvalid <= next_rvalid;  rresp <= next_rresp;  rdata <= next_rdata;
         awready <= next_awready;  wready <= next_wready;  arready <= next_arready;
      end
   end

   // Outputs straight from flip-flops
   assign MEM_REQ_O = req;
   assign FIFO_LOCK_O = lock;
   assign ERR_IRQ_O = irq;
   assign S_AXI_AWREADY_O = awready;
   assign S_AXI_WREADY_O = wready;
   assign S_AXI_BVALID_O = bvalid;
   assign S_AXI_BRESP_O = bresp;
   assign S_AXI_ARREADY_O = arready;
   assign S_AXI_RVALID_O = rvalid;
   assign S_AXI_RDATA_O = rdata;
   assign S_AXI_RRESP_O = rresp;

   // ==========================================================================
   // Checks
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   sequence s_cfg_rejected;
      state == ST_CHECK && cfg_bad ##1 chan_status_reg[dma_pkg::ST_CONFIG_ERROR_FLAG];
   endsequence
   a_cfg_no_bus: assert property (s_cfg_rejected |-> !req.valid [*2])
      else $error("bus request after settings rejected");
   a_big_size_rej: assert property (state == ST_CHECK && ctrl.xfer_size >= dma_pkg::SZ_16DW
      |=> chan_status_reg[3:0] == dma_pkg::CAUSE_CFG && state == ST_IDLE)
      else $error("oversized burst setting not rejected");
   a_burst_allowed: assert property (req.valid && req.len > 6'h01 |-> burst_ok)
      else $error("burst issued without buffer enable");
   a_no_boundary: assert property (req.valid && !req.addr[31] && req.len > 6'h01
      && !(req.write ? neg_dst : neg_src) |-> 6'(req.addr[7:3]) + req.len <= dma_pkg::BOUND_DW)
      else $error("burst crosses 32 double word boundary");
   a_src_single: assert property (req.valid && !req.write && ctrl.src_burst_inhibit
      |-> req.len == 6'h01)
      else $error("source burst despite inhibit");
   a_dst_single: assert property (req.valid && req.write && ctrl.dst_burst_inhibit
      |-> req.len == 6'h01)
      else $error("destination burst despite inhibit");
   a_fifo_bound: assert property (fifo_cnt <= 4'h8 && (!(req.valid && req.write)
      || 6'(fifo_cnt) >= beats))
      else $error("staging buffer over or under run");
   a_lock_hold: assert property (state == ST_CHECK && next_state == ST_RD && burst_ok
      && !ctrl.size_mode && offs_differ |=> FIFO_LOCK_O [*2])
      else $error("buffer lock missing for unequal offsets");
   a_err_irq: assert property ($rose(chan_status_reg[0]) && ctrl.err_ie |-> ERR_IRQ_O)
      else $error("error interrupt not raised");
   a_single_idle: assert property (state == ST_IDLE && start && ctrl.single_addr_select
      |=> state == ST_IDLE)
      else $error("single address setting started dual transfer");
endmodule // dma_dual_address_burst

/* File: tb/dma_dual_address_burst_tb_top.sv */
/* Bench for the dual-address DMA channel.
 Assumes the memory model answers every request of the channel. */
`timescale 1ns/10ps
module dma_dual_address_burst_tb_top;
   localparam logic [63:0] PAT = 64'h0123_4567_90AB_CDEF;
   logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rd, rdat;
   logic awr, wrd, bv, arr, rv, ack, irq, pv = 1'b0, lk, lks = 1'b0;
   logic [1:0] rsp, brs;
   logic [63:0] mrd, mwd;
   dma_pkg::mem_req_s req;
   int failures = 0, n_checks = 0, nreq = 0;
   always #2 clk = ~clk;
   dma_dual_address_burst dma_dual_address_burst_inst (.CORE_CLK_I(clk), .RST_I(rst),
      .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa), .S_AXI_WVALID_I(wv),
      .S_AXI_WREADY_O(wrd), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_BVALID_O(bv),
      .S_AXI_BREADY_I(bre), .S_AXI_BRESP_O(brs), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
      .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre), .S_AXI_RDATA_O(rdat),
      .S_AXI_RRESP_O(rsp), .MEM_REQ_O(req), .MEM_ACK_I(ack), .MEM_ERR_I(1'b0),
      .MEM_RDATA_I(mrd), .FIFO_BUSY_I(1'b0), .FIFO_LOCK_O(lk), .ERR_IRQ_O(irq));
   mem_model #(.PAT(PAT)) mem_model_inst (.clk_i(clk), .rst_i(rst), .req_i(req), .ack_o(ack),
      .rdata_o(mrd), .wdata_o(mwd));
   // Count system bus requests
   always @(posedge clk)
   begin
      if (req.valid && !pv) nreq++;
      pv = req.valid;
      lks = lks | lk;
   end
   task chk(input logic [63:0] g, input logic [63:0] e);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {awv, wv, bre, awa, wd} <= {3'h7, a, d};
      do begin @(posedge clk); if (awr) awv <= 1'b0; if (wrd) wv <= 1'b0; end while (!bv);
      bre <= 1'b0;
   endtask
   task rdr(input logic [7:0] a);
      @(posedge clk);
      {arv, rre, ara} <= {2'h3, a};
      do begin @(posedge clk); if (arr) arv <= 1'b0; end while (!rv);
      rre <= 1'b0;
      rd = rdat;
   endtask
   // Program a copy, start it, poll status until done, settings error or 100 reads
   task automatic run(input logic [31:0] ctl, input logic [31:0] cnt, input logic [5:0] est,
      input logic [31:0] src = 32'h100, input logic [31:0] dst = 32'h200,
      input logic [31:0] sinc = 32'h8, input logic [31:0] dinc = 32'h8);
      int i;
      wr(dma_pkg::OFS_STAT, 32'h3F);
      wr(dma_pkg::OFS_SRC, src);
      wr(dma_pkg::OFS_DST, dst);
      wr(dma_pkg::OFS_CNT, cnt);
      wr(dma_pkg::OFS_SINC, sinc);
      wr(dma_pkg::OFS_DINC, dinc);
      nreq = 0;
      lks = 1'b0;
      wr(dma_pkg::OFS_CTRL, ctl);
      i = 0;
      do begin rdr(dma_pkg::OFS_STAT); i++; end while (rd[5:4] == 2'h0 && i < 100);
      chk(rd[5:0], est);
   endtask
   task t_config;
      run(32'h20D, 32'h8, 6'h11);
      chk(nreq, 0);
      chk(irq, 1'b1);
      run(32'h00F, 32'h8, 6'h11);
      chk(irq, 1'b0);
      run(32'h003, 32'h5, 6'h11);
      chk(nreq, 0);
   endtask
   task t_single;
      run(32'h017, 32'h8, 6'h00);
      chk(nreq, 0);
      rdr(8'h40);
      chk(rsp, dma_pkg::RESP_DECERR);
      wr(8'h40, 32'h0);
      chk(brs, dma_pkg::RESP_DECERR);
   endtask
   task automatic t_reverse;
      logic [63:0] e;
      for (int k = 0; k < 8; k++) e[8*k+:8] = PAT[8*(7-k)+:8];
      run(32'h027, 32'h8, 6'h20);
      chk(nreq, 2);
      chk(mwd, e);
   endtask
   // Descending copies with inverted low address bits, and one left uninverted
   task t_descend;
      run(32'h007, 32'h8, 6'h20, 32'h107, 32'h200, 32'hFFFF_FFF8);
      chk(mwd, PAT);
      run(32'h007, 32'h8, 6'h11, 32'h100, 32'h200, 32'hFFFF_FFF8);
      run(32'h007, 32'h8, 6'h20, 32'h100, 32'h207, 32'h8, 32'hFFFF_FFF8);
      chk(mwd, PAT);
   endtask
   // Buffered bursts: aligned, unaligned equal and unequal offsets, size mode, inhibits
   task t_burst;
      wr(dma_pkg::OFS_MCTL, 32'h1);
      run(32'h00B, 32'h40, 6'h20);
      chk(nreq, 2);
      chk(mwd, PAT);
      chk(lks, 1'b0);
      run(32'h00B, 32'h40, 6'h20, 32'h128, 32'h228);
      chk(nreq, 4);
      run(32'h00B, 32'h40, 6'h20, 32'h100, 32'h208);
      chk(nreq, 3);
      chk(lks, 1'b1);
      run(32'h04B, 32'h40, 6'h20, 32'h100, 32'h208);
      chk(nreq, 2);
      chk(lks, 1'b0);
      run(32'h08B, 32'h40, 6'h20);
      chk(nreq, 16);
      run(32'h00B, 32'h40, 6'h11, 32'h100, 32'h200, 32'h8, 32'h0);
      run(32'h10B, 32'h40, 6'h20, 32'h100, 32'h200, 32'h8, 32'h0);
      chk(nreq, 9);
   endtask
   task complete_run;
      $display("checks %0d errors %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #60000;
      failures++;
      complete_run;
   end
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_config;
      t_single;
      t_reverse;
      t_descend;
      t_burst;
      complete_run;
   end
endmodule // dma_dual_address_burst_tb_top

/* File: tb/mem_model.sv */
/* System bus memory model for the DMA channel.
 Assumes one raised request at a time, one beat acked every other cycle. */
`timescale 1ns/10ps
module mem_model
#(parameter logic [63:0] PAT = 64'h0123_4567_90AB_CDEF)
(
   // Clock, reset, request
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire dma_pkg::mem_req_s req_i,
   // Answers
   output      logic              ack_o,
   output      logic [63:0]       rdata_o,
   output      logic [63:0]       wdata_o
);
   // ====================
   // Slow beat ack; read data toggles outside beats
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ack_o   <= 1'b0;
         rdata_o <= 64'h0;
         wdata_o <= 64'h0;
      end
      else
      begin
         ack_o   <= req_i.valid && !ack_o;
         rdata_o <= (req_i.valid && !ack_o) ? PAT : ~rdata_o;
         if (ack_o && req_i.write)
            wdata_o <= req_i.wdata; // Last written beat
      end
   end
endmodule // mem_model
